/* File: hw/ccr_regs.sv */
// channel calibration register bank with its APB slave
`timescale 1ns/1ps
module ccr_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ccr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ccr_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic                             pready,
  output logic      [ccr_pkg::DATA_W-1:0]  prdata,
  output logic                             pslverr,
  output logic signed [23:0]               ch0_offset,
  output logic      [23:0]                 ch0_gain,
  output logic signed [9:0]                ch1_phase_delay,
  output logic                             ch1_dc_block_off,
  output ccr_pkg::ccr_insel_t              ch1_input_select,
  output logic      [3:0]                  global_dc_block_setting,
  output logic      [3:0]                  ch1_dc_block_eff
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [3:0]        dc_eff;
  } ccr_state_t;

  ccr_state_t                st_reg;
  ccr_state_t                st_next;
  logic [NREG-1:0]           hit;
  logic                      miss;
  logic                      setup_ph;
  logic                      access_ph;
  logic                      wr_go;
  logic [NREG-1:0][REG_W-1:0] q;
  logic [REG_W-1:0]          rd_word;

  // bus phases
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_go     = access_ph & pwrite & ~miss;

  ccr_apb_decode u_dec (
    .paddr (paddr),
    .hit   (hit),
    .miss  (miss)
  );

  // one storage register per slot, reserved bits masked off
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    ccr_field_reg #(
      .RST   (REG_RST[i]),
      .WMASK (REG_WM[i])
    ) u_reg (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_go & hit[i]),
      .wr_data (pwdata[REG_W-1:0]),
      .byte_en (pstrb[1:0]),
      .q       (q[i])
    );
  end

  // read mux; unmapped reads give zero
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_word = q[i];
      end
    end
  end

  // read data captured in setup, effective dc filter tracked
  always_comb begin
    st_next = st_reg;
    if (setup_ph && !pwrite) begin
      st_next.rdata = {16'h0000, rd_word};
    end
    if (q[SLOT_CH1][DCOFF_BIT]) begin
      st_next.dc_eff = DCB_NONE;
    end else begin
      st_next.dc_eff = q[SLOT_THRESH][DCB_MSB:DCB_LSB];
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.rdata  <= '0;
      st_reg.dc_eff <= DCB_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus answers: zero wait, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = access_ph & miss;
  assign prdata  = st_reg.rdata;

  // datapath views of the fields
  assign ch0_offset = {q[SLOT_OFS_HI],
                       q[SLOT_OFS_LO][LOW8_MSB:LOW8_LSB]};
  assign ch0_gain   = {q[SLOT_GAIN_HI],
                       q[SLOT_GAIN_LO][LOW8_MSB:LOW8_LSB]};
  assign ch1_phase_delay  = q[SLOT_CH1][PHASE_MSB:PHASE_LSB];
  assign ch1_dc_block_off = q[SLOT_CH1][DCOFF_BIT];
  assign ch1_input_select = ccr_insel_t'(q[SLOT_CH1][MUX_MSB:MUX_LSB]);
  assign global_dc_block_setting = q[SLOT_THRESH][DCB_MSB:DCB_LSB];
  assign ch1_dc_block_eff = st_reg.dc_eff;

  // helper: high in the first cycle after reset release
  logic first_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // helper: full-lane write to a given index
  logic wr_full;
  assign wr_full = wr_go & (pstrb[1:0] == 2'h3);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // checks on field placement and read-back
  a_ofs_hi_write: assert property (
    wr_full && hit[SLOT_OFS_HI] |=> ch0_offset[23:8] == $past(pwdata[15:0])
  ) else $error("offset upper write not seen on offset bits 23:8");

  a_ofs_lo_place: assert property (
    wr_full && hit[SLOT_OFS_LO] |=> ch0_offset[7:0] == $past(pwdata[15:8])
  ) else $error("offset lower write not seen on offset bits 7:0");

  a_reset_defaults: assert property (
    first_reg |-> ch0_offset == 24'h000000 && prdata == 32'h00000000
  ) else $error("offset not zero after reset");

  a_gain_unity: assert property (
    first_reg |-> ch0_gain == 24'h800000
  ) else $error("gain not unity after reset");

  a_gain_hi_write: assert property (
    wr_full && hit[SLOT_GAIN_HI] |=> ch0_gain[23:8] == $past(pwdata[15:0])
  ) else $error("gain upper write not seen on gain bits 23:8");

  a_gain_lo_place: assert property (
    wr_full && hit[SLOT_GAIN_LO] ##1 !wr_go [*2]
      |-> ch0_gain[7:0] == $past(pwdata[15:8], 3)
  ) else $error("gain lower write not held on gain bits 7:0");

  a_low_rsvd_zero: assert property (
    setup_ph && !pwrite && (hit[SLOT_OFS_LO] || hit[SLOT_GAIN_LO])
      |=> prdata[7:0] == 8'h00
  ) else $error("reserved low byte read nonzero");

  a_ch1_rsvd_zero: assert property (
    setup_ph && !pwrite && hit[SLOT_CH1] |=> prdata[5:3] == 3'h0
  ) else $error("channel 1 reserved bits read nonzero");

  a_phase_write: assert property (
    wr_full && hit[SLOT_CH1] |=> ch1_phase_delay == $past(pwdata[15:6])
  ) else $error("phase delay not written");

  a_dc_effect: assert property (
    ##1 ch1_dc_block_eff ==
      ($past(ch1_dc_block_off) ? DCB_NONE : $past(global_dc_block_setting))
  ) else $error("effective dc filter setting wrong");

  a_input_sel: assert property (
    wr_full && hit[SLOT_CH1] |=> ch1_input_select == ccr_insel_t'($past(pwdata[1:0]))
  ) else $error("input selection not written");

  a_global_dcb: assert property (
    wr_full && hit[SLOT_THRESH] |=> global_dc_block_setting == $past(pwdata[3:0])
  ) else $error("global dc filter setting not written");

  a_hold_no_write: assert property (
    !wr_go |=> $stable(ch0_offset) && $stable(ch0_gain) && $stable(ch1_phase_delay)
  ) else $error("field changed without a write");

  a_err_unmapped: assert property (
    access_ph && miss |-> pslverr && pready
  ) else $error("unmapped access not flagged");

  // main scenarios
  c_gain_write: cover property (wr_full && hit[SLOT_GAIN_HI]);
  c_ch1_read:   cover property (setup_ph && !pwrite && hit[SLOT_CH1] ##1 access_ph);
  c_err_access: cover property (access_ph && miss);
  c_dc_off:     cover property ($rose(ch1_dc_block_off));

endmodule : ccr_regs

/* File: hw/ccr_pkg.sv */
// shared constants and types for the channel calibration register bank
package ccr_pkg;

  // bus and map geometry
  localparam int NREG   = 6;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_THRESH_LO = 6'h08;
  localparam logic [IDX_W-1:0] IDX_OFS_HI    = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_OFS_LO    = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_GAIN_HI   = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_GAIN_LO   = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CH1_CONFIG   = 6'h0E;

  // slot numbers inside the bank
  localparam int SLOT_THRESH = 0;
  localparam int SLOT_OFS_HI = 1;
  localparam int SLOT_OFS_LO = 2;
  localparam int SLOT_GAIN_HI = 3;
  localparam int SLOT_GAIN_LO = 4;
  localparam int SLOT_CH1    = 5;

  // reset values
  localparam logic [REG_W-1:0] RST_THRESH  = 16'h0000;
  localparam logic [REG_W-1:0] RST_OFS_HI  = 16'h0000;
  localparam logic [REG_W-1:0] RST_OFS_LO  = 16'h0000;
  localparam logic [REG_W-1:0] RST_GAIN_HI = 16'h8000;
  localparam logic [REG_W-1:0] RST_GAIN_LO = 16'h0000;
  localparam logic [REG_W-1:0] RST_CH1     = 16'h0000;

  // writable bits; all others are reserved and read zero
  localparam logic [REG_W-1:0] WM_THRESH = 16'h000F;
  localparam logic [REG_W-1:0] WM_FULL   = 16'hFFFF;
  localparam logic [REG_W-1:0] WM_LOW8   = 16'hFF00;
  localparam logic [REG_W-1:0] WM_CH1    = 16'hFFC7;

  localparam logic [NREG-1:0][IDX_W-1:0] REG_IDX = {IDX_CH1_CONFIG, IDX_GAIN_LO,
    IDX_GAIN_HI, IDX_OFS_LO, IDX_OFS_HI, IDX_THRESH_LO};
  localparam logic [NREG-1:0][REG_W-1:0] REG_RST = {RST_CH1, RST_GAIN_LO,
    RST_GAIN_HI, RST_OFS_LO, RST_OFS_HI, RST_THRESH};
  localparam logic [NREG-1:0][REG_W-1:0] REG_WM = {WM_CH1, WM_LOW8,
    WM_FULL, WM_LOW8, WM_FULL, WM_THRESH};

  // field positions
  localparam int LOW8_MSB  = 15;
  localparam int LOW8_LSB  = 8;
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 6;
  localparam int DCOFF_BIT = 2;
  localparam int MUX_MSB   = 1;
  localparam int MUX_LSB   = 0;
  localparam int DCB_MSB   = 3;
  localparam int DCB_LSB   = 0;
  localparam logic [3:0] DCB_NONE = 4'h0;

  typedef enum logic [1:0] {
    CCR_IN_PINS    = 2'h0,
    CCR_IN_SHORTED = 2'h1,
    CCR_IN_POS_TST = 2'h2,
    CCR_IN_NEG_TST = 2'h3
  } ccr_insel_t;

endpackage : ccr_pkg

/* File: hw/ccr_field_reg.sv */
// one 16-bit register with byte-lane writes and fixed writable mask
`timescale 1ns/1ps
module ccr_field_reg #(
  parameter logic [15:0] RST   = 16'h0000,
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  byte_en,
  output logic      [15:0] q
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [15:0] val;
  } ccr_fr_state_t;

  ccr_fr_state_t st_reg;
  ccr_fr_state_t st_next;
  logic [15:0]   lane_mask;

  // merge written lanes, reserved bits never change
  always_comb begin
    st_next   = st_reg;
    lane_mask = WMASK & {{8{byte_en[1]}}, {8{byte_en[0]}}};
    if (wr_en) begin
      st_next.val = (st_reg.val & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.val <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.val;
endmodule : ccr_field_reg

/* File: hw/ccr_apb_decode.sv */
// address decode of the register bank
`timescale 1ns/1ps
module ccr_apb_decode (
  input  wire logic [ccr_pkg::ADDR_W-1:0] paddr,
  output logic      [ccr_pkg::NREG-1:0]   hit,
  output logic                            miss
);
  import ccr_pkg::*;

  // one comparator per register; unaligned never hits
  for (genvar i = 0; i < NREG; i++) begin : g_hit
    assign hit[i] = (paddr[ADDR_W-1:2] == REG_IDX[i]) && (paddr[1:0] == 2'h0);
  end

  assign miss = ~|hit;
endmodule : ccr_apb_decode

/* File: tb/tb_top.sv */
// self-checking bench for the channel calibration register bank
`timescale 1ns/1ps
module tb_top;
  import ccr_pkg::*;

  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata;
  logic        [3:0]  pstrb;
  logic               pready;
  logic        [31:0] prdata;
  logic               pslverr;
  logic signed [23:0] ch0_offset;
  logic        [23:0] ch0_gain;
  logic signed [9:0]  ch1_phase_delay;
  logic               ch1_dc_block_off;
  ccr_insel_t         ch1_input_select;
  logic        [3:0]  global_dc_block_setting;
  logic        [3:0]  ch1_dc_block_eff;
  int                 error_cnt;
  int                 n_checks;
  logic        [31:0] seed;
  logic        [31:0] r;
  logic        [31:0] rd;
  logic               er;
  logic        [15:0] m [6];

  // byte addresses, writable masks and reset values of the six slots
  localparam logic [7:0]  ADR [6] = '{8'h20, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
  localparam logic [15:0] WM [6]  = '{16'h000F, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7};
  localparam logic [15:0] RV [6]  = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
  localparam logic [7:0]  BAD [4] = '{8'h00, 8'h24, 8'h3C, 8'h29};

  ccr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ch0_offset(ch0_offset), .ch0_gain(ch0_gain),
    .ch1_phase_delay(ch1_phase_delay), .ch1_dc_block_off(ch1_dc_block_off),
    .ch1_input_select(ch1_input_select), .global_dc_block_setting(global_dc_block_setting),
    .ch1_dc_block_eff(ch1_dc_block_eff));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, idle cycle before setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // datapath outputs against the model
  task automatic check_outs();
    chk({8'h00, ch0_offset}, {8'h00, m[1], m[2][15:8]});
    chk({8'h00, ch0_gain}, {8'h00, m[3], m[4][15:8]});
    chk({22'h0, ch1_phase_delay}, {22'h0, m[5][15:6]});
    chk({31'h0, ch1_dc_block_off}, {31'h0, m[5][2]});
    chk({30'h0, ch1_input_select}, {30'h0, m[5][1:0]});
    chk({28'h0, global_dc_block_setting}, {28'h0, m[0][3:0]});
    chk({28'h0, ch1_dc_block_eff}, m[5][2] ? 32'h0 : {28'h0, m[0][3:0]});
  endtask : check_outs

  // write a slot by lanes, update model, read back
  task automatic wr_reg(input int k, input logic [15:0] d, input logic [3:0] s);
    apb(1'b1, ADR[k], d, s, rd, er);
    chk({31'h0, er}, 32'h0);
    if (s[0]) m[k][7:0] = (m[k][7:0] & ~WM[k][7:0]) | (d[7:0] & WM[k][7:0]);
    if (s[1]) m[k][15:8] = (m[k][15:8] & ~WM[k][15:8]) | (d[15:8] & WM[k][15:8]);
    apb(1'b0, ADR[k], 16'h0000, 4'h0, rd, er);
    chk(rd, {16'h0000, m[k]});
    check_outs();
  endtask : wr_reg

  // reset for 20 cycles, then read every slot
  task automatic reset_check();
    presetn <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) m[k] = RV[k];
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ADR[k], 16'h0000, 4'h0, rd, er);
      chk(rd, {16'h0000, RV[k]});
    end
    check_outs();
    $display("test reset done");
  endtask : reset_check

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // hang guard
  initial begin
    repeat (8000) @(posedge pclk);
    error_cnt++;
    final_report();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    n_checks  = 0;
    seed      = 32'h6C1DC6DB;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    reset_check();
    wr_reg(0, 16'hFFF5, 4'h3);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wr_reg(5, {r[15:6], 3'b111, i[2:0]}, 4'h3);
    end
    wr_reg(1, 16'h8000, 4'h3);
    wr_reg(2, 16'hFFFF, 4'h3);
    wr_reg(3, 16'hFFFF, 4'h2);
    $display("test fields done");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      wr_reg(r[31:24] % 6, r[23:8], r[5:2]);
    end
    $display("test random done");
    foreach (BAD[j]) begin
      apb(1'b1, BAD[j], 16'hFFFF, 4'hF, rd, er);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, BAD[j], 16'h0000, 4'h0, rd, er);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ADR[k], 16'h0000, 4'h0, rd, er);
      chk(rd, {16'h0000, m[k]});
    end
    $display("test unmapped done");
    reset_check();
    final_report();
  end
endmodule : tb_top
